// [logic/lsscu_core.sv]
`timescale 1ns/1ps
module lsscu_core #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic                      mclk_in,
  input  wire logic                      rst_n_in,
  // Serial link
  input  wire logic                      serial_clk_in,
  input  wire logic                      serial_cmd_in,
  output logic                           serial_data_out,
  // Converter
  input  wire logic                      adc_valid_in,
  input  wire logic [7:0]                adc_code_in,
  output logic                           adc_req_out,
  output logic                           adc_ready_out,
  output logic [lsscu_pkg::PIX_W-1:0]    adc_index_out,
  // Array control and configuration
  output lsscu_pkg::lsscu_pix_t          pix_ctrl_out,
  output lsscu_pkg::lsscu_cfg_t          cfg_out,
  output logic                           dump_busy_out
);

  // ----------------------------------------------------------------
  // Register access functions
  // ----------------------------------------------------------------
  function automatic lsscu_pkg::lsscu_cfg_t cfg_write(
    input lsscu_pkg::lsscu_cfg_t c,
    input logic [4:0]            a,
    input logic [7:0]            d
  );
    lsscu_pkg::lsscu_cfg_t r;
    r = c;
    if (a == lsscu_pkg::ADDR_MODE) begin
      r.mode = d[3:0];
    end else if (a <= lsscu_pkg::ADDR_ZONE_LAST) begin
      if (a[0]) begin
        r.gain[a[2:1]] = d[4:0];
      end else begin
        r.offset[a[2:1]] = d;
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] cfg_read(
    input lsscu_pkg::lsscu_cfg_t c,
    input logic [4:0]            a
  );
    logic [7:0] r;
    r = 8'h00;
    if (a == lsscu_pkg::ADDR_MODE) begin
      r = {4'h0, c.mode};
    end else if (a <= lsscu_pkg::ADDR_ZONE_LAST) begin
      r = a[0] ? {3'h0, c.gain[a[2:1]]} : c.offset[a[2:1]];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------------------------------
  logic [1:0] sclk_sync_reg;
  logic [1:0] serial_cmd_in_sync_reg;
  logic       sclk_prev_reg;
  logic       sclk_rise;
  logic       sclk_fall;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_sync_reg <= 2'h0;
      serial_cmd_in_sync_reg <= 2'h3;
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], serial_clk_in};
      serial_cmd_in_sync_reg <= {serial_cmd_in_sync_reg[0], serial_cmd_in};
      sclk_prev_reg <= sclk_sync_reg[1];
    end
  end

  assign sclk_rise = sclk_sync_reg[1] && !sclk_prev_reg; // RULE22
  assign sclk_fall = !sclk_sync_reg[1] && sclk_prev_reg; // RULE22

  // ----------------------------------------------------------------
  // Command reception and decode
  // ----------------------------------------------------------------
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic       rx_brk;

  lsscu_rx u_rx (
    .clk_in         (mclk_in),
    .rst_n_in       (rst_n_in),
    .bit_en_in      (sclk_rise),
    .bit_in         (serial_cmd_in_sync_reg[1]),
    .byte_valid_out (rx_valid),
    .byte_out       (rx_byte),
    .brk_out        (rx_brk)
  );

  logic expect_data_reg;
  logic [4:0] wr_addr_reg;
  logic is_cmd;
  logic c_rst;
  logic c_start;
  logic c_smp;
  logic c_dump;
  logic c_cancel;
  logic c_sd;
  logic c_sdr;
  logic c_wr;
  logic c_rd;
  logic known;
  logic do_kill;
  logic do_sample;
  logic do_dump;
  logic do_start;
  logic cfg_wr;

  assign is_cmd   = rx_valid && !expect_data_reg; // RULE1
  assign c_rst    = is_cmd && rx_byte == lsscu_pkg::CMD_MAIN_RESET;
  assign c_start  = is_cmd && rx_byte == lsscu_pkg::CMD_BEGIN_INTEG;
  assign c_smp    = is_cmd && rx_byte == lsscu_pkg::CMD_SAMPLE_HOLD;
  assign c_dump   = is_cmd && rx_byte == lsscu_pkg::CMD_PIXEL_DUMP;
  assign c_cancel = is_cmd && rx_byte == lsscu_pkg::CMD_DUMP_CANCEL;
  assign c_sd     = is_cmd && rx_byte == lsscu_pkg::CMD_SAMPLE_DUMP;
  assign c_sdr    = is_cmd && rx_byte == lsscu_pkg::CMD_SAMPLE_RESTART;
  assign c_wr     = is_cmd && rx_byte[7:5] == lsscu_pkg::CMD_WRITE_PREFIX;
  assign c_rd     = is_cmd && rx_byte[7:5] == lsscu_pkg::CMD_FETCH_PREFIX;
  assign known    = c_rst | c_start | c_smp | c_dump | c_cancel | c_sd |
                    c_sdr | c_wr | c_rd; // RULE26
  assign do_kill   = c_rst | c_cancel; // RULE5 RULE15
  assign do_sample = c_smp | c_sd | c_sdr; // RULE16 RULE17
  assign do_dump   = c_dump | c_sd | c_sdr; // RULE16 RULE17
  assign do_start  = c_start | c_sdr; // RULE17
  assign cfg_wr    = rx_valid && expect_data_reg; // RULE18

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      expect_data_reg <= 1'b0;
      wr_addr_reg     <= 5'h00;
    end else if (rx_brk) begin
      expect_data_reg <= 1'b0; // RULE3
    end else if (rx_valid) begin
      expect_data_reg <= c_wr; // RULE1
      if (c_wr) begin
        wr_addr_reg <= rx_byte[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Zone registers
  // ----------------------------------------------------------------
  lsscu_pkg::lsscu_cfg_t cfg_reg;
  logic [7:0]            rd_sel;

  assign rd_sel  = cfg_read(cfg_reg, rx_byte[4:0]); // RULE19 RULE24
  assign cfg_out = cfg_reg;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_reg.offset <= {3{lsscu_pkg::OFFSET_RST}};
      cfg_reg.gain   <= {3{lsscu_pkg::GAIN_RST}};
      cfg_reg.mode   <= lsscu_pkg::MODE_RST;
    end else if (cfg_wr) begin
      cfg_reg <= cfg_write(cfg_reg, wr_addr_reg, rx_byte); // RULE18 RULE24
    end
  end

  // ----------------------------------------------------------------
  // Integrator control
  // ----------------------------------------------------------------
  lsscu_pkg::lsscu_pix_t pix_reg;
  logic                  start_pend_reg;
  logic [4:0]            start_cnt_reg;

  assign pix_ctrl_out = pix_reg;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pix_reg        <= '{integ_reset: 1'b1, default: 1'b0};
      start_pend_reg <= 1'b0;
      start_cnt_reg  <= 5'h00;
    end else if (do_kill) begin
      pix_reg        <= '{integ_reset: 1'b1, default: 1'b0}; // RULE5 RULE15
      start_pend_reg <= 1'b0;
    end else begin
      pix_reg.sample_pulse <= do_sample; // RULE10
      if (do_sample) begin
        pix_reg.hold_valid  <= 1'b1; // RULE10
        pix_reg.integ_run   <= 1'b0;
        pix_reg.integ_reset <= 1'b1;
      end
      if (do_start) begin
        start_pend_reg <= 1'b1;
        start_cnt_reg  <= lsscu_pkg::START_WAIT; // RULE9
      end else if (start_pend_reg && sclk_rise) begin
        // Integration begins only once auto-zero has had its clocks
        if (start_cnt_reg == 5'h01) begin
          start_pend_reg      <= 1'b0;
          pix_reg.integ_run   <= 1'b1; // RULE9
          pix_reg.integ_reset <= 1'b0;
        end else begin
          start_cnt_reg <= start_cnt_reg - 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Converter feed and pixel buffer
  // ----------------------------------------------------------------
  lsscu_pkg::lsscu_tx_t tx_state_reg;
  logic                 tx_dump_reg;
  logic [6:0]           adc_idx_reg;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic [7:0]           fifo_out_data;
  logic                 fifo_pop;
  logic                 start_dump;
  logic                 start_read;
  logic                 adc_take;

  assign start_dump    = do_dump && tx_state_reg == lsscu_pkg::TX_IDLE;
  assign start_read    = c_rd && tx_state_reg == lsscu_pkg::TX_IDLE;
  assign adc_req_out   = tx_dump_reg && adc_idx_reg < lsscu_pkg::PIXEL_COUNT;
  assign adc_ready_out = adc_req_out && fifo_in_ready;
  assign adc_take      = adc_valid_in && adc_ready_out;
  assign adc_index_out = adc_idx_reg;
  assign dump_busy_out = tx_dump_reg;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      adc_idx_reg <= 7'h00;
    end else if (do_kill || start_dump) begin
      adc_idx_reg <= 7'h00;
    end else if (adc_take) begin
      adc_idx_reg <= adc_idx_reg + 7'h01; // RULE13
    end
  end

  // Converter may run ahead of the line; a full buffer stalls it
  lsscu_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (mclk_in),
    .rst_n_in      (rst_n_in),
    .flush_in      (do_kill || start_dump),
    .in_valid_in   (adc_valid_in && adc_req_out),
    .in_data_in    (adc_code_in),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_out_valid),
    .out_data_out  (fifo_out_data),
    .out_ready_in  (fifo_pop)
  );

  // ----------------------------------------------------------------
  // Output framer
  // ----------------------------------------------------------------
  logic [4:0] tx_wait_reg;
  logic [8:0] tx_shift_reg;
  logic [3:0] tx_left_reg;
  logic [7:0] rd_byte_reg;
  logic [6:0] pix_cnt_reg;
  logic       frame_go;
  logic       dump_more;
  logic       frame_load;
  logic [7:0] frame_byte;

  assign frame_go   = sclk_fall &&
                      ((tx_state_reg == lsscu_pkg::TX_WAIT &&
                        tx_wait_reg == 5'h01) ||
                       (tx_state_reg == lsscu_pkg::TX_SEND &&
                        tx_left_reg == 4'h0));
  assign dump_more  = tx_dump_reg && pix_cnt_reg < lsscu_pkg::PIXEL_COUNT;
  assign fifo_pop   = frame_go && dump_more && fifo_out_valid; // RULE11
  assign frame_load = fifo_pop || (frame_go && !tx_dump_reg &&
                      tx_state_reg == lsscu_pkg::TX_WAIT);
  assign frame_byte = tx_dump_reg ? fifo_out_data : rd_byte_reg;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_state_reg    <= lsscu_pkg::TX_IDLE;
      tx_dump_reg     <= 1'b0;
      tx_wait_reg     <= 5'h00;
      tx_shift_reg    <= 9'h1FF;
      tx_left_reg     <= 4'h0;
      rd_byte_reg     <= 8'h00;
      pix_cnt_reg     <= 7'h00;
      serial_data_out <= 1'b1; // RULE8
    end else if (do_kill) begin
      // Line returns high at the next falling edge from idle
      tx_state_reg <= lsscu_pkg::TX_IDLE; // RULE5 RULE15
      tx_dump_reg  <= 1'b0;
      tx_left_reg  <= 4'h0;
    end else if (start_dump) begin
      tx_state_reg <= lsscu_pkg::TX_WAIT;
      tx_wait_reg  <= lsscu_pkg::DUMP_WAIT; // RULE14
      tx_dump_reg  <= 1'b1;
      pix_cnt_reg  <= 7'h00;
    end else if (start_read) begin
      tx_state_reg <= lsscu_pkg::TX_WAIT;
      tx_wait_reg  <= lsscu_pkg::READ_WAIT; // RULE20
      rd_byte_reg  <= rd_sel; // RULE19
    end else if (frame_load) begin
      serial_data_out <= 1'b0; // RULE12
      tx_shift_reg    <= {1'b1, frame_byte}; // RULE12
      tx_left_reg     <= lsscu_pkg::FRAME_LEFT;
      tx_state_reg    <= lsscu_pkg::TX_SEND;
      if (fifo_pop) begin
        pix_cnt_reg <= pix_cnt_reg + 7'h01; // RULE13
      end
    end else if (frame_go) begin
      // An empty buffer delays the frame rather than sending junk
      tx_state_reg <= dump_more ? lsscu_pkg::TX_WAIT : lsscu_pkg::TX_IDLE;
      tx_dump_reg  <= dump_more;
    end else if (sclk_fall) begin
      case (tx_state_reg)
        lsscu_pkg::TX_IDLE: begin
          serial_data_out <= 1'b1;
        end
        lsscu_pkg::TX_WAIT: begin
          tx_wait_reg <= tx_wait_reg - 5'h01;
        end
        default: begin
          serial_data_out <= tx_shift_reg[0]; // RULE12 RULE22
          tx_shift_reg    <= {1'b1, tx_shift_reg[8:1]};
          tx_left_reg     <= tx_left_reg - 4'h1; // RULE14
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  break_init_a: assert property (rx_brk |=> !expect_data_reg) // RULE3
    else $error("break did not clear data byte tracking");
  two_byte_a: assert property (c_wr |=> expect_data_reg) // RULE1
    else $error("write command did not await a data byte");
  gain_store_a: assert property ( // RULE18
    cfg_wr && wr_addr_reg == lsscu_pkg::ADDR_GAIN0
    |=> cfg_reg.gain[0] == $past(rx_byte[4:0]))
    else $error("gain write not stored");
  main_reset_a: assert property (c_rst |=> !dump_busy_out && // RULE5
    pix_ctrl_out.integ_reset && !pix_ctrl_out.hold_valid)
    else $error("main reset left activity running");
  cancel_a: assert property (c_cancel |=> tx_state_reg == // RULE15
    lsscu_pkg::TX_IDLE && !pix_ctrl_out.integ_run)
    else $error("cancel did not stop readout");
  start_delay_a: assert property ($rose(pix_ctrl_out.integ_run) // RULE9
    |-> $past(start_pend_reg) && $past(sclk_rise) &&
        $past(start_cnt_reg) == 5'h01)
    else $error("integration began before its delay");
  sample_a: assert property (do_sample && !do_kill |=> // RULE10
    pix_ctrl_out.hold_valid && pix_ctrl_out.integ_reset)
    else $error("sample did not hold and reset");
  macro_a: assert property (c_sdr && tx_state_reg == // RULE16 RULE17
    lsscu_pkg::TX_IDLE |=> start_pend_reg && dump_busy_out &&
    pix_ctrl_out.sample_pulse)
    else $error("restart macro incomplete");
  frame_start_a: assert property (frame_load |=> // RULE12
    !serial_data_out && tx_left_reg == lsscu_pkg::FRAME_LEFT)
    else $error("frame did not open with a start bit");
  pixel_order_a: assert property (fifo_pop |=> // RULE13
    pix_cnt_reg == $past(pix_cnt_reg) + 7'h01)
    else $error("pixel count did not advance by one");
  dump_wait_a: assert property (start_dump |=> // RULE14
    tx_state_reg == lsscu_pkg::TX_WAIT &&
    tx_wait_reg == lsscu_pkg::DUMP_WAIT)
    else $error("dump wait not loaded");
  read_wait_a: assert property (start_read |=> // RULE19 RULE20
    tx_wait_reg == lsscu_pkg::READ_WAIT && rd_byte_reg == $past(rd_sel))
    else $error("read not staged");
  fall_launch_a: assert property ( // RULE22
    !$stable(serial_data_out) |-> $past(sclk_fall))
    else $error("output changed off a falling edge");
  ignore_cmd_a: assert property (is_cmd && !known |=> // RULE26
    $stable(cfg_reg) && $stable(tx_state_reg) && $stable(start_pend_reg))
    else $error("unknown command changed state");

  dump_run_c: cover property (start_dump ##[1:1000] fifo_pop);
  reg_write_c: cover property (c_wr ##[1:100] cfg_wr);
  break_c: cover property (rx_brk);
  last_pixel_c: cover property (fifo_pop && pix_cnt_reg == 7'h65);

endmodule

// [logic/lsscu_fifo.sv]
`timescale 1ns/1ps
module lsscu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             flush_in,
  // Fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Drain side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  assign in_ready_out  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign out_valid_out = wr_ptr_reg != rd_ptr_reg;
  assign out_data_out  = mem_reg[rd_ptr_reg[AW-1:0]];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else if (flush_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
    end
  end

endmodule

// [logic/lsscu_pkg.sv]
// Overview of operation
// RULE1: Slave only; write takes two bytes
// RULE2: Host waits eight clocks between commands
// RULE3: Break character reinitialises command byte tracking
// RULE4: Host sends break first, once
// RULE5: Main reset aborts dump, resets integrators
// RULE6: Host idles input high thirty clocks
// RULE7: Host sends three main resets
// RULE8: Output undefined until after first reset
// RULE9: Begin integration twenty clocks after command
// RULE10: Sample holds integrators, returns them to reset
// RULE11: Dump converts each held pixel, shifts out
// RULE12: Frame: start zero, data LSB first, stop
// RULE13: Pixels go out zero through 101
// RULE14: First frame after twenty, then every ten
// RULE15: Cancel stops dump, resets integrators, drops hold
// RULE16: Sample dump equals sample then dump
// RULE17: Restart variant also begins integration
// RULE18: Prefix 010 plus address, then data stored
// RULE19: Prefix 011 reads addressed register LSB first
// RULE20: Read data appears four clocks later
// RULE21: Host programs zones before any dump
// RULE22: Input sampled rising, output launched falling
// RULE23: Command bytes framed with start and stop
// RULE24: Offsets at 0,2,4; gains 1,3,5; mode 1F
// RULE25: Host writes zeros to mode register
// RULE26: Unknown command bytes change nothing
package lsscu_pkg;

  // ----------------------------------------------------------------
  // Command encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_MAIN_RESET     = 8'h1B;
  localparam logic [7:0] CMD_BEGIN_INTEG    = 8'h08;
  localparam logic [7:0] CMD_SAMPLE_HOLD    = 8'h10;
  localparam logic [7:0] CMD_PIXEL_DUMP     = 8'h02;
  localparam logic [7:0] CMD_DUMP_CANCEL    = 8'h19;
  localparam logic [7:0] CMD_SAMPLE_DUMP    = 8'h12;
  localparam logic [7:0] CMD_SAMPLE_RESTART = 8'h16;
  localparam logic [2:0] CMD_WRITE_PREFIX   = 3'h2;
  localparam logic [2:0] CMD_FETCH_PREFIX   = 3'h3;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_OFFSET0   = 5'h00;
  localparam logic [4:0] ADDR_GAIN0     = 5'h01;
  localparam logic [4:0] ADDR_ZONE_LAST = 5'h05;
  localparam logic [4:0] ADDR_MODE      = 5'h1F;
  localparam logic [7:0] OFFSET_RST     = 8'h00;
  localparam logic [4:0] GAIN_RST       = 5'h00;
  localparam logic [3:0] MODE_RST       = 4'h0;

  // ----------------------------------------------------------------
  // Pixel width and count; waits and bit counts in serial clocks
  // ----------------------------------------------------------------
  localparam int         PIX_W        = 7;
  localparam logic [6:0] PIXEL_COUNT  = 7'h66;
  localparam logic [4:0] DUMP_WAIT    = 5'h14;
  localparam logic [4:0] START_WAIT   = 5'h14;
  localparam logic [4:0] READ_WAIT    = 5'h04;
  localparam logic [3:0] FRAME_LEFT   = 4'h9;
  localparam logic [3:0] RX_STOP_BIT  = 4'h9;
  localparam logic [3:0] RX_HOLD_LOW  = 4'hA;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0][7:0] offset;
    logic [2:0][4:0] gain;
    logic [3:0]      mode;
  } lsscu_cfg_t;

  typedef struct packed {
    logic integ_reset;
    logic integ_run;
    logic sample_pulse;
    logic hold_valid;
  } lsscu_pix_t;

  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} lsscu_tx_t;

endpackage

// [logic/lsscu_rx.sv]
`timescale 1ns/1ps
module lsscu_rx (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Sampled line
  input  wire logic       bit_en_in,
  input  wire logic       bit_in,
  // Received byte
  output logic            byte_valid_out,
  output logic [7:0]      byte_out,
  output logic            brk_out
);

  logic [3:0] cnt_reg;
  logic       stop_seen;

  // Bit counter: 0 idle, 1-8 data, 9 stop, 10 waiting for line high
  assign stop_seen = bit_en_in && (cnt_reg == lsscu_pkg::RX_STOP_BIT);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg        <= 4'h0;
      byte_out       <= 8'h00;
      byte_valid_out <= 1'b0;
      brk_out        <= 1'b0;
    end else begin
      byte_valid_out <= stop_seen && bit_in; // RULE23
      brk_out        <= stop_seen && !bit_in && (byte_out == 8'h00);
      if (bit_en_in) begin
        if (cnt_reg == 4'h0) begin
          cnt_reg <= bit_in ? 4'h0 : 4'h1;
        end else if (cnt_reg < lsscu_pkg::RX_STOP_BIT) begin
          byte_out <= {bit_in, byte_out[7:1]};
          cnt_reg  <= cnt_reg + 4'h1;
        end else if (cnt_reg == lsscu_pkg::RX_STOP_BIT) begin
          // A low stop bit is a break or a bad frame; let the line rise
          cnt_reg <= bit_in ? 4'h0 : lsscu_pkg::RX_HOLD_LOW;
        end else if (bit_in) begin
          cnt_reg <= 4'h0;
        end
      end
    end
  end

endmodule

// [sim/lsscu_host.sv]
`timescale 1ns/1ps
module lsscu_host #(
  parameter int HALF = 8
) (
  // Clock and answer
  input  wire logic mclk_in,
  input  wire logic sdo_in,
  // Host lines
  output logic      sclk_out,
  output logic      cmd_out
);
  int   cnt    = 0;
  logic sclk_q = 1'b0;
  logic cmd_q  = 1'b1;
  assign sclk_out = sclk_q;
  assign cmd_out  = cmd_q;
  // Runs free: command work and dump pacing need host clocks
  always @(negedge mclk_in) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) sclk_q <= ~sclk_q;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge sclk_out);
      cmd_q = f[i];
    end
    @(posedge sclk_out);
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge sclk_out);
  endtask
  task automatic brk();
    @(negedge sclk_out);
    cmd_q = 1'b0;
    repeat (12) @(negedge sclk_out);
    cmd_q = 1'b1;
  endtask
  task automatic recv(output logic [7:0] b, output int n, output logic s);
    n = 0;
    do begin
      @(posedge sclk_out);
      n++;
    end while (sdo_in !== 1'b0 && n < 400);
    for (int i = 0; i < 8; i++) begin
      @(posedge sclk_out);
      b[i] = sdo_in;
    end
    @(posedge sclk_out);
    s = sdo_in;
  endtask
endmodule

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
  logic                        mclk_in = 1'b0;
  logic                        rst_n_in = 1'b0;
  logic                        sclk, cmd, sdo, av, busy, req, rdy;
  logic                        took = 1'b0;
  logic [7:0]                  ac;
  logic [lsscu_pkg::PIX_W-1:0] idx;
  lsscu_pkg::lsscu_pix_t       pix;
  lsscu_pkg::lsscu_cfg_t       cfg;
  int bad_count = 0;
  int comparisons = 0;
  int regs [32];
  int base;
  always #4 mclk_in = ~mclk_in;
  lsscu_core i_lsscu_core (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .serial_clk_in(sclk), .serial_cmd_in(cmd), .serial_data_out(sdo),
    .adc_valid_in(av), .adc_code_in(ac), .adc_req_out(req),
    .adc_ready_out(rdy), .adc_index_out(idx), .pix_ctrl_out(pix),
    .cfg_out(cfg), .dump_busy_out(busy));
  lsscu_host i_lsscu_host (.mclk_in(mclk_in), .sdo_in(sdo),
    .sclk_out(sclk), .cmd_out(cmd));
  // Converter stand-in stalls at random, holds a code until taken
  always @(posedge mclk_in) took <= av && rdy;
  always @(negedge mclk_in) begin
    if (av !== 1'b1 || took) av <= 1'($urandom);
    ac <= 8'(int'(idx) * 37 + base);
  end
  task automatic check(input string w, input logic [63:0] s, e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", w, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic lsscu_pkg::lsscu_cfg_t mcfg();
    lsscu_pkg::lsscu_cfg_t c;
    for (int z = 0; z < 3; z++) begin
      c.offset[z] = 8'(regs[2*z]);
      c.gain[z] = 5'(regs[2*z+1]);
    end
    c.mode = 4'(regs[31]);
    return c;
  endfunction
  task automatic cmd1(input logic [7:0] b);
    i_lsscu_host.send(b);
    i_lsscu_host.gap(10);
  endtask
  initial begin
    #700_000;
    bad_count++;
    stop_test();
  end
  initial begin
    logic [7:0] b, d;
    int n, a;
    logic s;
    void'($urandom(32'hBB72));
    base = $urandom;
    repeat (8) @(posedge mclk_in);
    @(negedge mclk_in) rst_n_in = 1'b1;
    i_lsscu_host.gap(30);
    i_lsscu_host.brk();
    i_lsscu_host.gap(30);
    repeat (3) cmd1(8'h1B);
    i_lsscu_host.gap(30);
    check("reset", pix.integ_reset, 1);
    for (int k = 0; k < 8; k++) begin
      a = (k == 6) ? 31 : (k == 7) ? 9 : k;
      d = (a == 31) ? 8'h00 : 8'($urandom);
      cmd1(8'h40 | 8'(a));
      cmd1(d);
      if (a < 6) regs[a] = (a % 2) ? (d & 8'h1F) : d;
      if (a == 31) regs[a] = d & 8'h0F;
    end
    check("cfg", cfg, mcfg());
    for (int k = 0; k < 8; k++) begin
      a = (k == 6) ? 31 : (k == 7) ? 9 : k;
      i_lsscu_host.send(8'h60 | 8'(a));
      i_lsscu_host.recv(b, n, s);
      check("rd", {n, b, s}, {32'h4, 8'(regs[a]), 1'b1});
      i_lsscu_host.gap(10);
    end
    cmd1(8'hA5);
    cmd1(8'h00);
    check("unk", {cfg, busy}, {mcfg(), 1'b0});
    i_lsscu_host.send(8'h16);
    repeat (6) @(negedge mclk_in);
    check("samp", {pix.hold_valid, pix.integ_run}, 2'b10);
    for (int p = 0; p < 102; p++) begin
      i_lsscu_host.recv(b, n, s);
      a = (p == 0) ? 20 : 1;
      check("pix", {n, b, s}, {a, 8'(p * 37 + base), 1'b1});
    end
    check("run", pix.integ_run, 1);
    i_lsscu_host.gap(12);
    check("end", {busy, sdo, req, idx}, {3'b010, 7'h66});
    for (int k = 0; k < 2; k++) begin
      i_lsscu_host.send(8'h12);
      for (int p = 0; p < 3; p++) begin
        i_lsscu_host.recv(b, n, s);
        a = (p == 0) ? 20 : 1;
        check("pix2", {n, b, s}, {a, 8'(p * 37 + base), 1'b1});
      end
      cmd1(k ? 8'h1B : 8'h19);
      check("abort", {busy, sdo, pix}, {2'b01, 4'b1000});
    end
    stop_test();
  end
endmodule
